//--- rtl/adfd_map.svh
/*
  Register indices, field positions, reset values and sizes of the
  converter sync, decimation and threshold-flag register slice.
  Assumes a byte address equal to four times the index.
*/
`ifndef ADFD_MAP_SVH
`define ADFD_MAP_SVH

// ============================================================
// register indices (byte address = index * 4)
`define ADFD_IDX_SYNC_WIN  10'h128
`define ADFD_IDX_SYNC_PH   10'h129
`define ADFD_IDX_SYNC_CNT  10'h12a
`define ADFD_IDX_SYNC_MODE 10'h1ff
`define ADFD_IDX_APP_MODE  10'h200
`define ADFD_IDX_DECIM     10'h201
`define ADFD_IDX_OFFSET    10'h228
`define ADFD_IDX_FD_CTL    10'h245
`define ADFD_IDX_UP_LO     10'h247
`define ADFD_IDX_UP_HI     10'h248
`define ADFD_IDX_LO_LO     10'h249
`define ADFD_IDX_LO_HI     10'h24a
`define ADFD_IDX_CH_SEL    10'h3f0
`define ADFD_IDX_IRQ_STAT  10'h3f1
`define ADFD_IDX_IRQ_MASK  10'h3f2

// ============================================================
// field positions
`define ADFD_FD_EN     0
`define ADFD_FD_FVAL   2
`define ADFD_FD_FORCE  3
`define ADFD_APP_QIGN  5
`define ADFD_IRQ_SYNC  0
`define ADFD_IRQ_FD0   1
`define ADFD_IRQ_FD1   2

// ============================================================
// reset values and sizes
`define ADFD_RST_8     8'h00
`define ADFD_RST_THR   13'h0000
`define ADFD_NCH       2
`define ADFD_THR_W     13
`define ADFD_NIRQ      3

`endif

//--- rtl/adfd_pkg.sv
/*
  Types of the threshold-flag register slice.
  Assumes adfd_map.svh is on the include path.
*/
`include "adfd_map.svh"

package adfd_pkg;

  // ============================================================
  // main block state
  typedef struct packed {
    logic [2:0] sync_pipe;
    logic [7:0] sync_cnt;
    logic [1:0] sync_mode;
    logic [7:0] app_mode;
    logic [1:0] decim;
    logic [3:0] decim_factor;
    logic q_ignore;
    logic ch_sel;
    logic [`ADFD_NCH-1:0][7:0] offset;
    logic [`ADFD_NCH-1:0][7:0] fd_ctl;
    logic [`ADFD_NCH-1:0][`ADFD_THR_W-1:0] up;
    logic [`ADFD_NCH-1:0][`ADFD_THR_W-1:0] lo;
    logic [`ADFD_NCH-1:0] flag_prev;
    logic [`ADFD_NCH-1:0] fd_out;
    logic [`ADFD_NIRQ-1:0] irq_stat;
    logic [`ADFD_NIRQ-1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } adfd_state_t;

  // ============================================================
  // detector state
  typedef struct packed {
    logic flag;
  } adfd_det_t;

endpackage

//--- rtl/adfd_det_if.sv
/*
  Carries one channel's magnitude, thresholds and flag between the
  register slice and its threshold detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`include "adfd_map.svh"

interface adfd_det_if;
  logic [`ADFD_THR_W-1:0] mag;
  logic [`ADFD_THR_W-1:0] upper;
  logic [`ADFD_THR_W-1:0] lower;
  logic flag;
  modport ctl (output mag, output upper, output lower, input flag);
  modport det (input mag, input upper, input lower, output flag);
endinterface

//--- rtl/adfd_detect.sv
/*
  Hysteresis threshold detector of one channel.
  Assumes magnitude and thresholds come from logic on pclk.
*/
`timescale 1ns/10ps

module adfd_detect
  import adfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  adfd_det_if.det dif
);

  adfd_det_t s_q;
  adfd_det_t s_d;

  // ============================================================
  // hysteresis
  always_comb begin
    s_d = s_q;
    if (dif.mag > dif.upper) begin
      s_d.flag = 1'b1;
    end else if (dif.mag < dif.lower) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dif.flag = s_q.flag;

  // ============================================================
  // checks
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    dif.mag > dif.upper |=> dif.flag)
    else $error("flag not set above upper threshold");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    dif.flag && !(dif.mag < dif.lower) |=> dif.flag)
    else $error("flag dropped before lower threshold");

  flag_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dif.flag && !(dif.mag > dif.upper) |=> !dif.flag)
    else $error("flag rose without exceeding upper");

endmodule // adfd_detect

//--- rtl/adfd_regs.sv
/*
  Sync status, chip mode, decimation and threshold-flag register slice
  of a dual-channel converter, reached over APB.
  Assumes sample magnitudes and sync monitor status on pclk; the sync
  pin is asynchronous.
*/
// Notes on behaviour
// - q-ignore bit selects in-phase only output
// - decimation codes select 1, 2, 4, 8
// - force bit overrides flag pins per channel
// - forced pins carry the force-value bit
// - enable bit gates flag output, reset off
`timescale 1ns/10ps
`include "adfd_map.svh"

module adfd_regs
  import adfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_in,
  input wire logic [7:0] sync_window,
  input wire logic [3:0] sync_phase,
  input wire logic [2*`ADFD_THR_W-1:0] sample_mag,
  output logic threshold_flag_out_first,
  output logic threshold_flag_out_second,
  output logic q_ignore,
  output logic [1:0] operating_mode,
  output logic [3:0] decim_factor,
  output logic [1:0] sync_mode,
  output logic [15:0] offset_adjust,
  output logic irq
);

  adfd_state_t s_q;
  adfd_state_t s_d;
  logic [`ADFD_NCH-1:0] flag;

  // ============================================================
  // per-channel detectors
  genvar g;
  generate
    for (g = 0; g < `ADFD_NCH; g++) begin : ch
      adfd_det_if dif ();
      assign dif.mag = sample_mag[g*`ADFD_THR_W +: `ADFD_THR_W];
      assign dif.upper = s_q.up[g];
      assign dif.lower = s_q.lo[g];
      assign flag[g] = dif.flag;
      adfd_detect u_det (
        .pclk(pclk),
        .presetn(presetn),
        .dif(dif)
      );
    end
  endgenerate

  // ============================================================
  // next state
  always_comb begin
    logic [9:0] idx;
    logic setup;
    logic wr;
    logic hit;
    logic [7:0] rd;
    logic [7:0] wd;
    logic cap;
    logic [`ADFD_NIRQ-1:0] ev;
    logic [`ADFD_NIRQ-1:0] clr;
    idx = paddr[11:2];
    setup = psel && !penable;
    wr = psel && penable && s_q.pready && pwrite;
    hit = 1'b1;
    rd = 8'h00;
    wd = pwdata[7:0];
    ev = '0;
    clr = '0;
    s_d = s_q;

    // sync pin: two flops, then edge detect
    s_d.sync_pipe = {s_q.sync_pipe[1:0], sync_in};
    cap = s_q.sync_pipe[1] && !s_q.sync_pipe[2];
    if (cap) begin
      s_d.sync_cnt = s_q.sync_cnt + 8'h01;
    end

    // address decode, read data and writes
    if (idx == `ADFD_IDX_SYNC_WIN) begin
      rd = sync_window;
    end else if (idx == `ADFD_IDX_SYNC_PH) begin
      rd = {4'h0, sync_phase};
    end else if (idx == `ADFD_IDX_SYNC_CNT) begin
      rd = s_q.sync_cnt;
    end else if (idx == `ADFD_IDX_SYNC_MODE) begin
      rd = {6'h00, s_q.sync_mode};
      if (wr) s_d.sync_mode = wd[1:0];
    end else if (idx == `ADFD_IDX_APP_MODE) begin
      rd = s_q.app_mode;
      if (wr) s_d.app_mode = wd & 8'h23;
    end else if (idx == `ADFD_IDX_DECIM) begin
      rd = {6'h00, s_q.decim};
      if (wr) s_d.decim = wd[1:0];
    end else if (idx == `ADFD_IDX_OFFSET) begin
      rd = s_q.offset[s_q.ch_sel];
      if (wr) s_d.offset[s_q.ch_sel] = wd;
    end else if (idx == `ADFD_IDX_FD_CTL) begin
      rd = s_q.fd_ctl[s_q.ch_sel];
      if (wr) s_d.fd_ctl[s_q.ch_sel] = wd & 8'h0d;
    end else if (idx == `ADFD_IDX_UP_LO) begin
      rd = s_q.up[s_q.ch_sel][7:0];
      if (wr) s_d.up[s_q.ch_sel][7:0] = wd;
    end else if (idx == `ADFD_IDX_UP_HI) begin
      rd = {3'h0, s_q.up[s_q.ch_sel][12:8]};
      if (wr) s_d.up[s_q.ch_sel][12:8] = wd[4:0];
    end else if (idx == `ADFD_IDX_LO_LO) begin
      rd = s_q.lo[s_q.ch_sel][7:0];
      if (wr) s_d.lo[s_q.ch_sel][7:0] = wd;
    end else if (idx == `ADFD_IDX_LO_HI) begin
      rd = {3'h0, s_q.lo[s_q.ch_sel][12:8]};
      if (wr) s_d.lo[s_q.ch_sel][12:8] = wd[4:0];
    end else if (idx == `ADFD_IDX_CH_SEL) begin
      rd = {7'h00, s_q.ch_sel};
      if (wr) s_d.ch_sel = wd[0];
    end else if (idx == `ADFD_IDX_IRQ_STAT) begin
      rd = {5'h00, s_q.irq_stat};
      if (wr) clr = wd[`ADFD_NIRQ-1:0];
    end else if (idx == `ADFD_IDX_IRQ_MASK) begin
      rd = {5'h00, s_q.irq_mask};
      if (wr) s_d.irq_mask = wd[`ADFD_NIRQ-1:0];
    end else begin
      hit = 1'b0;
    end

    // apb answer: ready in the first access cycle
    s_d.pready = setup;
    if (setup) begin
      s_d.prdata = {24'h000000, rd};
      s_d.pslverr = !hit;
    end else begin
      s_d.pslverr = 1'b0;
    end

    // chip controls
    s_d.q_ignore = s_q.app_mode[`ADFD_APP_QIGN];
    s_d.decim_factor = 4'h1 << s_q.decim;

    // flag outputs per channel
    s_d.flag_prev = flag;
    for (int i = 0; i < `ADFD_NCH; i++) begin
      if (s_q.fd_ctl[i][`ADFD_FD_FORCE]) begin
        s_d.fd_out[i] = s_q.fd_ctl[i][`ADFD_FD_FVAL];
      end else begin
        s_d.fd_out[i] = s_q.fd_ctl[i][`ADFD_FD_EN] && flag[i];
      end
    end

    // interrupts: set wins over clear
    ev[`ADFD_IRQ_SYNC] = cap;
    ev[`ADFD_IRQ_FD0] = flag[0] && !s_q.flag_prev[0];
    ev[`ADFD_IRQ_FD1] = flag[1] && !s_q.flag_prev[1];
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    s_d.irq = |(s_q.irq_stat & s_q.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign threshold_flag_out_first = s_q.fd_out[0];
  assign threshold_flag_out_second = s_q.fd_out[1];
  assign q_ignore = s_q.q_ignore;
  assign operating_mode = s_q.app_mode[1:0];
  assign decim_factor = s_q.decim_factor;
  assign sync_mode = s_q.sync_mode;
  assign offset_adjust = {s_q.offset[1], s_q.offset[0]};
  assign irq = s_q.irq;

  // ============================================================
  // checks
  logic acc_wr;
  logic [9:0] acc_idx;
  assign acc_wr = psel && penable && pready && pwrite;
  assign acc_idx = paddr[11:2];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  mode_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_SYNC_MODE |=> sync_mode == $past(pwdata[1:0]))
    else $error("sync mode write lost");

  app_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_APP_MODE |=> s_q.app_mode == ($past(pwdata[7:0]) & 8'h23))
    else $error("application mode write lost");

  decim_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_DECIM |=> s_q.decim == $past(pwdata[1:0]))
    else $error("decimation write lost");

  offset_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_OFFSET |=> s_q.offset[$past(s_q.ch_sel)] == $past(pwdata[7:0]))
    else $error("offset write lost");

  fdctl_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_FD_CTL
    |=> s_q.fd_ctl[$past(s_q.ch_sel)] == ($past(pwdata[7:0]) & 8'h0d))
    else $error("flag control write lost");

  upper_low_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_UP_LO |=> s_q.up[$past(s_q.ch_sel)][7:0] == $past(pwdata[7:0]))
    else $error("upper threshold low write lost");

  upper_high_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_UP_HI |=> s_q.up[$past(s_q.ch_sel)][12:8] == $past(pwdata[4:0]))
    else $error("upper threshold high write lost");

  lower_low_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_LO_LO |=> s_q.lo[$past(s_q.ch_sel)][7:0] == $past(pwdata[7:0]))
    else $error("lower threshold low write lost");

  lower_high_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_LO_HI |=> s_q.lo[$past(s_q.ch_sel)][12:8] == $past(pwdata[4:0]))
    else $error("lower threshold high write lost");

  chsel_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_CH_SEL |=> s_q.ch_sel == $past(pwdata[0]))
    else $error("channel select write lost");

  mask_write_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_IRQ_MASK |=> s_q.irq_mask == $past(pwdata[2:0]))
    else $error("interrupt mask write lost");

  stat_sticky_a: assert property (
    !(acc_wr && acc_idx == `ADFD_IDX_IRQ_STAT) |=> (s_q.irq_stat & $past(s_q.irq_stat)) == $past(s_q.irq_stat))
    else $error("status bit lost without clear");

  stat_clear_a: assert property (
    acc_wr && acc_idx == `ADFD_IDX_IRQ_STAT && pwdata[0] && !(s_q.sync_pipe[1] && !s_q.sync_pipe[2])
    |=> !s_q.irq_stat[`ADFD_IRQ_SYNC])
    else $error("status bit not cleared by write of one");

  sync_irq_a: assert property (
    s_q.sync_pipe[1] && !s_q.sync_pipe[2] |=> s_q.irq_stat[`ADFD_IRQ_SYNC])
    else $error("sync capture did not set status");

  rise_first_a: assert property (
    flag[0] && !s_q.flag_prev[0] |=> s_q.irq_stat[`ADFD_IRQ_FD0])
    else $error("first flag rise did not set status");

  rise_second_a: assert property (
    flag[1] && !s_q.flag_prev[1] |=> s_q.irq_stat[`ADFD_IRQ_FD1])
    else $error("second flag rise did not set status");

  read_pad_a: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  err_ready_a: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  window_read_a: assert property (
    psel && !penable && acc_idx == `ADFD_IDX_SYNC_WIN |=> prdata[7:0] == $past(sync_window))
    else $error("sync window read wrong");

  phase_read_a: assert property (
    psel && !penable && acc_idx == `ADFD_IDX_SYNC_PH |=> prdata[7:0] == {4'h0, $past(sync_phase)})
    else $error("sync phase read wrong");

  count_read_a: assert property (
    psel && !penable && acc_idx == `ADFD_IDX_SYNC_CNT |=> prdata[7:0] == $past(s_q.sync_cnt))
    else $error("sync counter read wrong");

  enable_second_a: assert property (
    !s_q.fd_ctl[1][`ADFD_FD_FORCE] |=>
    threshold_flag_out_second == ($past(s_q.fd_ctl[1][`ADFD_FD_EN]) && $past(flag[1])))
    else $error("second flag output not gated by enable");

  sync_count_a: assert property (
    s_q.sync_pipe[1] && !s_q.sync_pipe[2] |=> s_q.sync_cnt == $past(s_q.sync_cnt) + 8'h01)
    else $error("sync counter did not advance on capture");

  sync_still_a: assert property (
    !(s_q.sync_pipe[1] && !s_q.sync_pipe[2]) |=> $stable(s_q.sync_cnt))
    else $error("sync counter moved without capture");

  qign_follow_a: assert property (
    psel && penable && pready && pwrite && paddr[11:2] == `ADFD_IDX_APP_MODE
    |-> ##2 q_ignore == $past(pwdata[`ADFD_APP_QIGN], 2))
    else $error("q-ignore output did not follow write");

  decim_code_a: assert property (
    $past(presetn) |-> decim_factor == (4'h1 << $past(s_q.decim)) && $onehot(decim_factor))
    else $error("decimation factor decode wrong");

  force_level_a: assert property (
    s_q.fd_ctl[0][`ADFD_FD_FORCE]
    |=> threshold_flag_out_first == $past(s_q.fd_ctl[0][`ADFD_FD_FVAL]))
    else $error("first flag pin not forced");

  force_second_a: assert property (
    s_q.fd_ctl[1][`ADFD_FD_FORCE]
    |=> threshold_flag_out_second == $past(s_q.fd_ctl[1][`ADFD_FD_FVAL]))
    else $error("second flag pin not forced");

  enable_gate_a: assert property (
    !s_q.fd_ctl[0][`ADFD_FD_FORCE] |=>
    threshold_flag_out_first == ($past(s_q.fd_ctl[0][`ADFD_FD_EN]) && $past(flag[0])))
    else $error("flag output not gated by enable");

  irq_level_a: assert property (
    ##1 irq == $past(|(s_q.irq_stat & s_q.irq_mask)))
    else $error("interrupt level wrong");

  apb_ready_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single access cycle");

  sync_seen_c: cover property (s_q.sync_pipe[1] && !s_q.sync_pipe[2] ##1 irq);
  force_seen_c: cover property (s_q.fd_ctl[0][`ADFD_FD_FORCE] ##1 threshold_flag_out_first);
  flag_seen_c: cover property ($rose(flag[1]) ##2 threshold_flag_out_second);
  err_seen_c: cover property (pready && pslverr);
  decim_seen_c: cover property (decim_factor == 4'h8);

endmodule // adfd_regs

//--- tb/adfd_regs_tb.sv
/* apb driver, fixed expected-value checks of the register slice and an integer model of flag hysteresis.
   assumes adfd_regs and the indices of adfd_map.svh. */
`timescale 1ns/10ps
`include "adfd_map.svh"
module adfd_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sync_in = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] sync_window = 0, sw;
  logic [3:0] sync_phase = 0, decim_factor;
  logic [25:0] sample_mag = 0;
  logic [1:0] operating_mode, sync_mode;
  logic [15:0] offset_adjust;
  logic pready, pslverr, err, q_ignore, irq, fo0, fo1;
  int failures = 0, tests_run = 0, seed = 15176, fl, rose, m;
  bit q[$];
  logic [9:0] rw[9] = '{10'h1ff, 10'h200, 10'h201, 10'h228, 10'h245,
    10'h247, 10'h248, 10'h249, 10'h24a};

  adfd_regs u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_in(sync_in), .sync_window(sync_window),
    .sync_phase(sync_phase), .sample_mag(sample_mag), .threshold_flag_out_first(fo0),
    .threshold_flag_out_second(fo1), .q_ignore(q_ignore), .operating_mode(operating_mode),
    .decim_factor(decim_factor), .sync_mode(sync_mode), .offset_adjust(offset_adjust),
    .irq(irq));

  always #50 pclk = ~pclk;

  // ============================================================
  // checks and bus tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rdc(input string n, input logic [9:0] idx, input logic [31:0] e);
    apb(0, idx, 0);
    chk(n, rd, e);
  endtask

  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test;
  end

  // ============================================================
  // main sequence
  initial begin
    wt(6);
    presetn <= 1;
    foreach (rw[i]) rdc("reset value", rw[i], 0);
    apb(0, 10'h3ff, 0);
    chk("unmapped error", err, 1);
    $display("test reset done");
    sw = $random(seed);
    sync_window <= sw;
    sync_phase <= sw[3:0];
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk) sync_in <= 1;
      wt(3);
      sync_in <= 0;
      wt(3);
    end
    rdc("sync count", `ADFD_IDX_SYNC_CNT, 3);
    apb(1, `ADFD_IDX_SYNC_CNT, 8'hff);
    rdc("count read only", `ADFD_IDX_SYNC_CNT, 3);
    rdc("sync window", `ADFD_IDX_SYNC_WIN, sw);
    rdc("sync phase", `ADFD_IDX_SYNC_PH, sw[3:0]);
    rdc("irq status", `ADFD_IDX_IRQ_STAT, 1);
    chk("irq masked", irq, 0);
    apb(1, `ADFD_IDX_IRQ_MASK, 7);
    wt(2);
    chk("irq on", irq, 1);
    apb(1, `ADFD_IDX_IRQ_STAT, 1);
    wt(2);
    chk("irq cleared", irq, 0);
    $display("test sync done");
    apb(1, `ADFD_IDX_APP_MODE, 8'hff);
    rdc("app mode", `ADFD_IDX_APP_MODE, 8'h23);
    wt(2);
    chk("q ignore on", q_ignore, 1);
    chk("op mode", operating_mode, 3);
    apb(1, `ADFD_IDX_APP_MODE, 0);
    wt(2);
    chk("q ignore off", q_ignore, 0);
    for (int c = 0; c < 4; c++) begin
      apb(1, `ADFD_IDX_DECIM, c);
      wt(2);
      chk("decim factor", decim_factor, 1 << c);
      rdc("decim code", `ADFD_IDX_DECIM, c);
    end
    apb(1, `ADFD_IDX_SYNC_MODE, 1);
    apb(1, `ADFD_IDX_CH_SEL, 0);
    apb(1, `ADFD_IDX_OFFSET, 8'h7f);
    apb(1, `ADFD_IDX_CH_SEL, 1);
    apb(1, `ADFD_IDX_OFFSET, 8'h80);
    wt(2);
    chk("sync mode", sync_mode, 1);
    chk("offsets", offset_adjust, 16'h807f);
    $display("test modes done");
    apb(1, `ADFD_IDX_FD_CTL, 8'hff);
    rdc("fd control", `ADFD_IDX_FD_CTL, 8'h0d);
    wt(3);
    chk("forced high", fo1, 1);
    apb(1, `ADFD_IDX_FD_CTL, 8'h08);
    wt(3);
    chk("forced low", fo1, 0);
    apb(1, `ADFD_IDX_FD_CTL, 0);
    apb(1, `ADFD_IDX_CH_SEL, 0);
    apb(1, `ADFD_IDX_UP_LO, 8'h64);
    apb(1, `ADFD_IDX_LO_LO, 8'h32);
    apb(1, `ADFD_IDX_FD_CTL, 1);
    fl = 0;
    rose = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge pclk);
      if (q.size() == 3) chk("flag pin", fo0, q.pop_front());
      m = $unsigned($random(seed)) % 160;
      if (m > 100) begin
        rose |= !fl;
        fl = 1;
      end else if (m < 50) fl = 0;
      q.push_back(fl);
      sample_mag <= {13'h0, m[12:0]};
    end
    rdc("flag irq", `ADFD_IDX_IRQ_STAT, rose << 1);
    sample_mag <= 26'd200;
    wt(4);
    chk("flag set", fo0, 1);
    apb(1, `ADFD_IDX_FD_CTL, 0);
    wt(3);
    chk("flag disabled", fo0, 0);
    $display("test flags done");
    stop_test;
  end
endmodule // adfd_regs_tb
